// File: verilog/dwtc_pkg.sv
// Package with constants and types of the DRAM width and timing control.
package dwtc_pkg;

    // Register byte addresses on the APB bus.
    localparam logic [31:0] DWTC_CFG_ADDR = 32'h032000d0;
    localparam logic [31:0] DWTC_STAT_ADDR = 32'h032000dc;

    // Field positions inside the configuration register.
    localparam int DWTC_WIDTH_LSB = 0;
    localparam int DWTC_EDO_BIT = 4;
    localparam int DWTC_RCD_BIT = 5;
    localparam int DWTC_PRECH_BIT = 6;
    localparam int DWTC_CFG_BITS = 7;

    // Reset value: all banks 32-bit, Fast Page, no extra cycles.
    localparam logic [6:0] DWTC_CFG_RESET = 7'h00;

    // Timing counts in memory clock cycles.
    localparam logic [2:0] DWTC_PRECH_BASE = 3'h3;
    localparam logic [2:0] DWTC_PRECH_EXT = 3'h4;
    localparam logic [2:0] DWTC_BANK_GAP = 3'h2;
    localparam logic [1:0] DWTC_RCD_BASE = 2'h2;
    localparam logic [1:0] DWTC_RCD_EXT = 2'h3;
    localparam logic [2:0] DWTC_HIGH_MAX = 3'h7;

    // Request address bits that pick the bank.
    localparam int DWTC_BANK_HI = 27;
    localparam int DWTC_BANK_LO = 26;

    // Read data placement codes for the capture pipe.
    localparam logic [1:0] DWTC_RD_FULL = 2'h0;
    localparam logic [1:0] DWTC_RD_UPPER = 2'h1;
    localparam logic [1:0] DWTC_RD_LOWER = 2'h2;
    localparam logic [1:0] DWTC_RD_REPL = 2'h3;

    // Configuration fields, packed in register bit order 6 down to 0.
    typedef struct packed {
        logic prech_ext;
        logic rcd_ext;
        logic edo_select;
        logic [3:0] width16;
    } dwtc_cfg_s;

    // Access sequencer states.
    typedef enum logic [1:0] {
        DWTC_IDLE = 2'b00,
        DWTC_RCD = 2'b01,
        DWTC_CAS = 2'b10,
        DWTC_END = 2'b11
    } dwtc_state_e;

    // Register slave state.
    typedef struct packed {
        dwtc_cfg_s cfg;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dwtc_regs_s;

    // Pins driven toward the DRAM devices.
    typedef struct packed {
        logic [3:0] row_strobe_n;
        logic [3:0] column_strobe_n;
        logic we_n;
        logic [11:0] dram_mux_address;
        logic [31:0] wdata;
        logic wdata_oe;
    } dwtc_pins_s;

endpackage : dwtc_pkg

// File: verilog/dwtc_timer.sv
// Loadable down counter that flags when it has reached zero.
`timescale 1ns/100ps
module dwtc_timer #(
    parameter int W = 2
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    output logic zero_o
);

    typedef struct packed {
        logic [W-1:0] count;
    } dwtc_tmr_s;

    dwtc_tmr_s s_reg;
    dwtc_tmr_s s_next;

    // Load wins over counting; counting stops at zero.
    always_comb begin
        s_next = s_reg;
        if (load_i) begin
            s_next.count = load_val_i;
        end else if (s_reg.count != '0) begin
            s_next.count = s_reg.count - 1'b1;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign zero_o = (s_reg.count == '0);

endmodule : dwtc_timer

// File: verilog/dwtc_regs.sv
// APB slave holding the DRAM configuration and status registers.
`timescale 1ns/100ps
module dwtc_regs (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [7:0] status_i,
    output dwtc_pkg::dwtc_cfg_s cfg_o
);

    dwtc_pkg::dwtc_regs_s s_reg;
    dwtc_pkg::dwtc_regs_s s_next;
    logic hit_cfg;
    logic hit_stat;

    assign hit_cfg = (paddr_i == dwtc_pkg::DWTC_CFG_ADDR);
    assign hit_stat = (paddr_i == dwtc_pkg::DWTC_STAT_ADDR);

    // Answer is prepared in the setup cycle and given in the first access
    // cycle; a write lands on the edge that completes the access.
    always_comb begin
        s_next = s_reg;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        if (psel_i && !penable_i) begin
            s_next.pready = 1'b1;
            s_next.pslverr = !(hit_cfg || hit_stat);
            s_next.prdata = 32'h00000000;
            if (hit_cfg) begin
                s_next.prdata[dwtc_pkg::DWTC_CFG_BITS-1:0] = s_reg.cfg;
            end else if (hit_stat) begin
                s_next.prdata[7:0] = status_i;
            end
        end
        if (psel_i && penable_i && s_reg.pready && pwrite_i && hit_cfg) begin
            s_next.cfg = pwdata_i[dwtc_pkg::DWTC_CFG_BITS-1:0];
        end
    end

    // State register; reset gives 32-bit banks and Fast Page timing.
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            s_reg.cfg <= dwtc_pkg::DWTC_CFG_RESET;
            s_reg.prdata <= 32'h00000000;
            s_reg.pready <= 1'b0;
            s_reg.pslverr <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata_o = s_reg.prdata;
    assign pready_o = s_reg.pready;
    assign pslverr_o = s_reg.pslverr;
    assign cfg_o = s_reg.cfg;

endmodule : dwtc_regs

// File: verilog/dwtc_top.sv
// DRAM access sequencer with per-bank width and timing configuration.
// Function
// - One width bit per bank in bits 3..0, 1 means 16-bit, readable.
// - Reset clears all width bits, so every bank is 32-bit.
// - Reset clears EDO, RAS-to-CAS extend and precharge extend.
// - Same-bank reopen keeps row strobe high 3 cycles, 4 when extended.
// - At least 2 cycles between row strobe rise and another bank's fall.
// - Row to first column strobe fall is 2 cycles, 3 when extended.
// - Fast Page reads capture data at end of column strobe low time.
// - EDO reads capture data 2 cycles after column strobe falls.
// - Each access ends with a cycle of row low and column strobes high.
// - 32-bit byte access uses one column strobe from address bits 1:0.
// - 16-bit word takes two accesses on strobes 1:0, strobes 3:2 high.
// - 16-bit banks keep the upper half-word at the lower location.
// - 16-bit byte access: one access, column LSB plus strobes 1:0.
// - 16-bit word: non-sequential upper half then sequential lower half.
// - 16-bit banks use the same address count, so 32MB per bank.
// - Row strobe line is decoded from request address bits 27:26.
// - 16-bit addresses are shifted up one bit before multiplexing.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
module dwtc_top (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic req_valid_i,
    input wire logic [27:0] req_addr_i,
    input wire logic req_write_i,
    input wire logic req_byte_i,
    input wire logic [31:0] req_wdata_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [31:0] rsp_rdata_o,
    output logic [3:0] row_strobe_n_o,
    output logic [3:0] column_strobe_n_o,
    output logic dram_we_n_o,
    output logic [11:0] dram_mux_address_o,
    output logic [31:0] dram_wdata_o,
    output logic dram_wdata_oe_o,
    input wire logic [31:0] dram_rdata_i
);

    typedef struct packed {
        dwtc_pkg::dwtc_state_e state;
        dwtc_pkg::dwtc_pins_s pins;
        logic req_ready;
        logic rsp_valid;
        logic [31:0] rsp_rdata;
        logic [1:0] bank;
        logic write;
        logic w16;
        logic two_half;
        logic half;
        logic [3:0] lanes;
        logic [23:0] lin;
        logic [31:0] wdata;
        dwtc_pkg::dwtc_cfg_s cfg;
        logic [2:0] high_cnt;
        logic [1:0] prev_bank;
        logic [31:0] rd_s1;
        logic [31:0] rd_s2;
        logic [1:0] cap;
        logic [1:0] mode0;
        logic [1:0] mode1;
        logic last0;
        logic last1;
    } dwtc_seq_s;

    dwtc_seq_s s_reg;
    dwtc_seq_s s_next;
    dwtc_pkg::dwtc_cfg_s cfg;
    logic [7:0] status;
    logic tmr_load;
    logic [1:0] tmr_val;
    logic tmr_zero;

    // Decoded view of the waiting request under the live configuration.
    logic [1:0] n_bank;
    logic n_w16;
    logic [23:0] n_lin;
    logic [3:0] n_lanes;
    logic [2:0] need_m1;
    logic page_hit;
    logic can_take;

    // Status register: busy state, open row, current bank.
    assign status = {3'h0, ~&s_reg.pins.row_strobe_n, s_reg.bank,
                     s_reg.state};

    dwtc_regs u_regs (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .status_i(status),
        .cfg_o(cfg)
    );

    dwtc_timer #(
        .W(2)
    ) u_rcd_timer (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .load_i(tmr_load),
        .load_val_i(tmr_val),
        .zero_o(tmr_zero)
    );

    // Request decode: bank, width, linear DRAM address and strobe lanes.
    always_comb begin
        n_bank = req_addr_i[dwtc_pkg::DWTC_BANK_HI:dwtc_pkg::DWTC_BANK_LO];
        n_w16 = cfg.width16[n_bank];
        if (n_w16) begin
            // Bit 25 is dropped, halving the bank to 32MB.
            n_lin = {req_addr_i[24:2], 1'b0};
            if (req_byte_i) begin
                n_lin[0] = ~req_addr_i[1];
                n_lanes = req_addr_i[0] ? 4'h2 : 4'h1;
            end else begin
                n_lanes = 4'h3;
            end
        end else begin
            n_lin = req_addr_i[25:2];
            if (req_byte_i) begin
                n_lanes = 4'(4'h1 << req_addr_i[1:0]);
            end else begin
                n_lanes = 4'hf;
            end
        end
        if (n_bank == s_reg.prev_bank) begin
            need_m1 = (cfg.prech_ext ? dwtc_pkg::DWTC_PRECH_EXT
                                     : dwtc_pkg::DWTC_PRECH_BASE) - 3'h1;
        end else begin
            need_m1 = dwtc_pkg::DWTC_BANK_GAP - 3'h1;
        end
        can_take = req_valid_i && !s_reg.req_ready;
        page_hit = can_take && (n_bank == s_reg.bank) &&
                   (n_lin[23:12] == s_reg.lin[23:12]) && (cfg == s_reg.cfg) &&
                   !(req_write_i && !s_reg.write && s_reg.cfg.edo_select);
    end

    // Sequencer, read capture pipe and pin drive.
    always_comb begin
        s_next = s_reg;
        s_next.req_ready = 1'b0;
        s_next.rsp_valid = 1'b0;
        tmr_load = 1'b0;
        tmr_val = 2'h0;
        // Read data pins pass two flip-flops before use.
        s_next.rd_s1 = dram_rdata_i;
        s_next.rd_s2 = s_reg.rd_s1;
        s_next.cap = {s_reg.cap[0], 1'b0};
        s_next.mode1 = s_reg.mode0;
        s_next.last1 = s_reg.last0;
        if (s_reg.cap[1]) begin
            unique case (s_reg.mode1)
                dwtc_pkg::DWTC_RD_FULL: s_next.rsp_rdata = s_reg.rd_s2;
                dwtc_pkg::DWTC_RD_UPPER: begin
                    s_next.rsp_rdata[31:16] = s_reg.rd_s2[15:0];
                end
                dwtc_pkg::DWTC_RD_LOWER: begin
                    s_next.rsp_rdata[15:0] = s_reg.rd_s2[15:0];
                end
                dwtc_pkg::DWTC_RD_REPL: begin
                    s_next.rsp_rdata = {s_reg.rd_s2[15:0], s_reg.rd_s2[15:0]};
                end
            endcase
            s_next.rsp_valid = s_reg.last1;
        end
        // Cycles with every row strobe high, saturating.
        if (s_reg.state == dwtc_pkg::DWTC_IDLE &&
            s_reg.high_cnt != dwtc_pkg::DWTC_HIGH_MAX) begin
            s_next.high_cnt = s_reg.high_cnt + 3'h1;
        end
        unique case (s_reg.state)
            dwtc_pkg::DWTC_IDLE: begin
                if (can_take && s_reg.high_cnt >= need_m1) begin
                    s_next.req_ready = 1'b1;
                    s_next.cfg = cfg;
                    s_next.bank = n_bank;
                    s_next.prev_bank = n_bank;
                    s_next.write = req_write_i;
                    s_next.w16 = n_w16;
                    s_next.two_half = n_w16 && !req_byte_i;
                    s_next.half = 1'b0;
                    s_next.lanes = n_lanes;
                    s_next.lin = n_lin;
                    s_next.wdata = req_wdata_i;
                    s_next.pins.row_strobe_n = ~(4'(4'h1 << n_bank));
                    s_next.pins.dram_mux_address = n_lin[23:12];
                    s_next.pins.we_n = !req_write_i;
                    s_next.pins.wdata_oe = req_write_i;
                    s_next.pins.wdata = n_w16 ?
                        {16'h0000, n_lin[0] ? req_wdata_i[15:0]
                                            : req_wdata_i[31:16]}
                        : req_wdata_i;
                    tmr_load = 1'b1;
                    tmr_val = (cfg.rcd_ext ? dwtc_pkg::DWTC_RCD_EXT
                                           : dwtc_pkg::DWTC_RCD_BASE) - 2'h1;
                    s_next.state = dwtc_pkg::DWTC_RCD;
                end
            end
            dwtc_pkg::DWTC_RCD: begin
                if (tmr_zero) begin
                    s_next.pins.column_strobe_n = ~s_reg.lanes;
                    s_next.pins.dram_mux_address = s_reg.lin[11:0];
                    s_next.state = dwtc_pkg::DWTC_CAS;
                end
            end
            dwtc_pkg::DWTC_CAS: begin
                s_next.pins.column_strobe_n = 4'hf;
                s_next.state = dwtc_pkg::DWTC_END;
                if (!s_reg.write && !s_reg.cfg.edo_select) begin
                    s_next.cap[0] = 1'b1;
                    s_next.last0 = !(s_reg.two_half && !s_reg.half);
                    s_next.mode0 = !s_reg.w16 ? dwtc_pkg::DWTC_RD_FULL :
                        !s_reg.two_half ? dwtc_pkg::DWTC_RD_REPL :
                        s_reg.half ? dwtc_pkg::DWTC_RD_LOWER
                                   : dwtc_pkg::DWTC_RD_UPPER;
                end
            end
            dwtc_pkg::DWTC_END: begin
                if (!s_reg.write && s_reg.cfg.edo_select) begin
                    s_next.cap[0] = 1'b1;
                    s_next.last0 = !(s_reg.two_half && !s_reg.half);
                    s_next.mode0 = !s_reg.w16 ? dwtc_pkg::DWTC_RD_FULL :
                        !s_reg.two_half ? dwtc_pkg::DWTC_RD_REPL :
                        s_reg.half ? dwtc_pkg::DWTC_RD_LOWER
                                   : dwtc_pkg::DWTC_RD_UPPER;
                end
                if (s_reg.write && !(s_reg.two_half && !s_reg.half)) begin
                    s_next.rsp_valid = 1'b1;
                end
                if (s_reg.two_half && !s_reg.half) begin
                    // Lower half at the next location, page mode.
                    s_next.half = 1'b1;
                    s_next.lin[0] = 1'b1;
                    s_next.pins.dram_mux_address = {s_reg.lin[11:1], 1'b1};
                    s_next.pins.wdata = {16'h0000, s_reg.wdata[15:0]};
                    s_next.pins.column_strobe_n = ~s_reg.lanes;
                    s_next.state = dwtc_pkg::DWTC_CAS;
                end else if (page_hit) begin
                    // Sequential access inside the open row.
                    s_next.req_ready = 1'b1;
                    s_next.write = req_write_i;
                    s_next.two_half = n_w16 && !req_byte_i;
                    s_next.half = 1'b0;
                    s_next.lanes = n_lanes;
                    s_next.lin = n_lin;
                    s_next.wdata = req_wdata_i;
                    s_next.pins.we_n = !req_write_i;
                    s_next.pins.wdata_oe = req_write_i;
                    s_next.pins.wdata = n_w16 ?
                        {16'h0000, n_lin[0] ? req_wdata_i[15:0]
                                            : req_wdata_i[31:16]}
                        : req_wdata_i;
                    s_next.pins.dram_mux_address = n_lin[11:0];
                    s_next.pins.column_strobe_n = ~n_lanes;
                    s_next.state = dwtc_pkg::DWTC_CAS;
                end else begin
                    // Close the row and start counting precharge.
                    s_next.pins.row_strobe_n = 4'hf;
                    s_next.pins.we_n = 1'b1;
                    s_next.pins.wdata_oe = 1'b0;
                    s_next.high_cnt = 3'h0;
                    s_next.state = dwtc_pkg::DWTC_IDLE;
                end
            end
        endcase
    end

    // State register; reset leaves all strobes inactive high.
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
            s_reg.state <= dwtc_pkg::DWTC_IDLE;
            s_reg.pins.row_strobe_n <= 4'hf;
            s_reg.pins.column_strobe_n <= 4'hf;
            s_reg.pins.we_n <= 1'b1;
            s_reg.cfg <= dwtc_pkg::DWTC_CFG_RESET;
            s_reg.high_cnt <= dwtc_pkg::DWTC_HIGH_MAX;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs come straight from the state register.
    assign req_ready_o = s_reg.req_ready;
    assign rsp_valid_o = s_reg.rsp_valid;
    assign rsp_rdata_o = s_reg.rsp_rdata;
    assign row_strobe_n_o = s_reg.pins.row_strobe_n;
    assign column_strobe_n_o = s_reg.pins.column_strobe_n;
    assign dram_we_n_o = s_reg.pins.we_n;
    assign dram_mux_address_o = s_reg.pins.dram_mux_address;
    assign dram_wdata_o = s_reg.pins.wdata;
    assign dram_wdata_oe_o = s_reg.pins.wdata_oe;

endmodule : dwtc_top

// File: test/dwtc_properties.sv
// Concurrent checks on the ports of the DRAM width and timing control.
`timescale 1ns/100ps
module dwtc_properties (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic [27:0] req_addr_i,
    input wire logic req_byte_i,
    input wire logic req_ready_o,
    input wire logic [3:0] row_strobe_n_o,
    input wire logic [3:0] column_strobe_n_o,
    input wire logic dram_wdata_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    logic [6:0] cfg;
    logic [3:0] row_q;
    logic [2:0] gap, hi [4];
    logic byte_q, fell, bad, is_cfg;
    // Shadow of the configuration and saturating idle counters per bank.
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cfg <= 7'h00;
            row_q <= 4'hf;
            gap <= 3'h7;
            byte_q <= 1'b0;
            for (int i = 0; i < 4; i++) hi[i] <= 3'h7;
        end else begin
            if (psel_i && penable_i && pready_o && pwrite_i && is_cfg)
                cfg <= pwdata_i[6:0];
            row_q <= row_strobe_n_o;
            gap <= !(&row_strobe_n_o) ? 3'h0 : gap + {2'h0, gap != 3'h7};
            if (req_ready_o) byte_q <= req_byte_i;
            for (int i = 0; i < 4; i++)
                hi[i] <= !row_strobe_n_o[i] ? 3'h0 : hi[i] + {2'h0, hi[i] != 3'h7};
        end
    end
    assign is_cfg = paddr_i == dwtc_pkg::DWTC_CFG_ADDR;
    assign fell = |(row_q & ~row_strobe_n_o);
    // Flags a bank whose row strobe falls before its precharge has run.
    always_comb begin
        bad = 1'b0;
        for (int i = 0; i < 4; i++)
            if (row_q[i] && !row_strobe_n_o[i] && hi[i] < (cfg[6] ? 3'h4 : 3'h3))
                bad = 1'b1;
    end
    a_prech_same: assert property (!bad)
        else $error("row strobe reopened before its precharge time");
    a_bank_gap: assert property (fell |-> gap >= 3'h2)
        else $error("row strobe fell too soon after another bank");
    a_rcd_base: assert property (fell && !cfg[5] |-> ##1 (&column_strobe_n_o) ##1 column_strobe_n_o != 4'hf)
        else $error("row to column delay is not two cycles");
    a_rcd_ext: assert property (fell && cfg[5] |-> ##1 (&column_strobe_n_o) [*2] ##1 column_strobe_n_o != 4'hf)
        else $error("row to column delay is not three cycles");
    a_cas_end: assert property ($rose(&column_strobe_n_o) |-> row_strobe_n_o != 4'hf)
        else $error("row strobe rose together with column strobes");
    a_half_lanes: assert property (|(~row_strobe_n_o & cfg[3:0]) |-> column_strobe_n_o[3:2] == 2'b11)
        else $error("upper column strobes used in a 16-bit bank");
    a_byte_lane: assert property ((req_ready_o ? req_byte_i : byte_q) && column_strobe_n_o != 4'hf |-> $onehot(~column_strobe_n_o))
        else $error("byte access drives more than one column strobe");
    a_bank_sel: assert property (req_ready_o |-> row_strobe_n_o == ~(4'h1 << req_addr_i[27:26]))
        else $error("row strobe does not match the request bank");
    a_oe_in_row: assert property (dram_wdata_oe_o |-> row_strobe_n_o != 4'hf)
        else $error("write data driven with no row open");
    a_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("register access not answered in its first access cycle");
    a_cfg_read: assert property (pready_o && psel_i && !pwrite_i && is_cfg |-> prdata_o == {25'h0, cfg})
        else $error("configuration read differs from the last write");
    c_rcd_ext: cover property (fell && cfg[5]);
    c_half: cover property (|(~row_strobe_n_o & cfg[3:0]) && column_strobe_n_o != 4'hf);
    c_byte: cover property (req_ready_o && req_byte_i);
endmodule : dwtc_properties

bind dwtc_top dwtc_properties CHK (.clk_sys_i, .nrst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .req_addr_i,
    .req_byte_i, .req_ready_o, .row_strobe_n_o, .column_strobe_n_o,
    .dram_wdata_oe_o);

// File: test/dwtc_dram_model.sv
// Behavioural Fast Page or EDO DRAM array behind the four row strobes.
`timescale 1ns/100ps
module dwtc_dram_model (
    input wire logic clk_sys_i,
    input wire logic edo_i,
    input wire logic [3:0] row_n_i,
    input wire logic [3:0] col_n_i,
    input wire logic we_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [logic [25:0]];
    logic [11:0] row_q [4];
    logic [3:0] rq = 4'hf;
    logic [31:0] held = 32'h0;
    logic [31:0] w;
    logic [1:0] bank;
    logic [25:0] key;
    function automatic logic [31:0] peek(input logic [25:0] k);
        return mem.exists(k) ? mem[k] : {6'h0, k};
    endfunction : peek
    // Location addressed by the open bank, its latched row and the column.
    always_comb begin
        bank = 2'h0;
        for (int i = 0; i < 4; i++) if (!row_n_i[i]) bank = 2'(i);
        key = {bank, row_q[bank], addr_i};
    end
    // Fast Page data only while a column strobe is low; EDO holds it on.
    assign rdata_o = (!(&col_n_i) && we_n_i) ? peek(key) :
        (edo_i && !(&row_n_i)) ? held : ~held;
    // Row latch on the falling row strobe and lane writes under column strobes.
    always @(posedge clk_sys_i) begin
        for (int i = 0; i < 4; i++) if (rq[i] && !row_n_i[i]) row_q[i] <= addr_i;
        rq <= row_n_i;
        if (!(&col_n_i)) begin
            w = peek(key);
            for (int i = 0; i < 4; i++)
                if (!col_n_i[i]) w[8*i+:8] = wdata_i[8*i+:8];
            if (!we_n_i) mem[key] = w;
            else held <= peek(key);
        end
    end
endmodule : dwtc_dram_model

// File: test/dwtc_top_bench.sv
// Self-checking bench for the DRAM width and timing control.
`timescale 1ns/100ps
module dwtc_top_bench;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o;
    logic pready_o, pslverr_o, req_ready_o, rsp_valid_o;
    logic req_valid_i = 1'b0, req_write_i = 1'b0, req_byte_i = 1'b0;
    logic [27:0] req_addr_i = 28'h0;
    logic [31:0] req_wdata_i = 32'h0, rsp_rdata_o, dram_wdata_o, dram_rdata_i;
    logic [3:0] row_strobe_n_o, column_strobe_n_o;
    logic dram_we_n_o, dram_wdata_oe_o, edo = 1'b0;
    logic [11:0] dram_mux_address_o;
    logic [32:0] exp_q [$];
    logic [6:0] cfgs [5] = '{7'h00, 7'h10, 7'h20, 7'h40, 7'h75};
    logic [27:0] ofs [3] = '{28'h0, 28'h4, 28'h8000000};
    logic [31:0] r, w;
    logic e;
    int fails = 0, n_tests = 0, cyc = 0;
    dwtc_top DUT (.clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .req_valid_i,
        .req_addr_i, .req_write_i, .req_byte_i, .req_wdata_i, .req_ready_o,
        .rsp_valid_o, .rsp_rdata_o, .row_strobe_n_o, .column_strobe_n_o,
        .dram_we_n_o, .dram_mux_address_o, .dram_wdata_o, .dram_wdata_oe_o,
        .dram_rdata_i);
    dwtc_dram_model MDL (.clk_sys_i, .edo_i(edo), .row_n_i(row_strobe_n_o),
        .col_n_i(column_strobe_n_o), .we_n_i(dram_we_n_o),
        .addr_i(dram_mux_address_o), .wdata_i(dram_wdata_o),
        .rdata_o(dram_rdata_i));
    // Clock at 200 MHz.
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] pat(input int k);
        return 32'h12345678 + 32'(32'h01000001 * k);
    endfunction : pat
    task automatic final_report;
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One APB transfer: setup, then access until the slave is ready.
    task automatic apb(input logic wr, input logic [31:0] a, d,
        output logic [31:0] rd, output logic err);
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    // Presents one DRAM request and returns at the edge that takes it.
    task automatic issue(input logic wr, by, input logic [27:0] a,
        input logic [31:0] d);
        req_valid_i <= 1'b1;
        req_write_i <= wr;
        req_byte_i <= by;
        req_addr_i <= a;
        req_wdata_i <= d;
        exp_q.push_back({~wr, d});
        do @(posedge clk_sys_i); while (req_ready_o !== 1'b1);
    endtask : issue
    task automatic drain;
        req_valid_i <= 1'b0;
        while (exp_q.size() != 0) @(posedge clk_sys_i);
    endtask : drain
    // Responses come back in request order; reads are compared.
    always @(posedge clk_sys_i) begin
        if (rsp_valid_o === 1'b1 && exp_q.size() != 0) begin
            if (exp_q[0][32]) check("read data", rsp_rdata_o, exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
    end
    // Hang guard well above the length of the run.
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        apb(1'b0, dwtc_pkg::DWTC_CFG_ADDR, 32'h0, r, e);
        check("config after reset", r, 32'h0);
        check("row strobes idle", {28'h0, row_strobe_n_o}, 32'hf);
        apb(1'b1, dwtc_pkg::DWTC_CFG_ADDR, 32'hffffffff, r, e);
        apb(1'b0, dwtc_pkg::DWTC_CFG_ADDR, 32'h0, r, e);
        check("config readback", r, 32'h7f);
        apb(1'b0, 32'h032000e0, 32'h0, r, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        // Each mode: two banks, a sequential pair, then reopen and read back.
        foreach (cfgs[k]) begin
            apb(1'b1, dwtc_pkg::DWTC_CFG_ADDR, {25'h0, cfgs[k]}, r, e);
            edo <= cfgs[k][4];
            for (int j = 0; j < 6; j++)
                issue(j < 3, 1'b0, (28'(k) << 14) | ofs[j % 3], pat(3 * k + j % 3));
            drain();
        end
        w = pat(12);
        check("upper half first", MDL.peek({2'h0, 12'h8, 12'h0}) & 32'hffff, w >> 16);
        check("lower half next", MDL.peek({2'h0, 12'h8, 12'h1}) & 32'hffff, w & 32'hffff);
        for (int i = 0; i < 4; i++)
            issue(1'b1, 1'b1, 28'h4000000 + 28'(i), 32'(8'h11 * (i + 1)) << (8 * i));
        issue(1'b0, 1'b0, 28'h4000000, 32'h44332211);
        issue(1'b1, 1'b1, 28'h0010001, 32'h0000ab00);
        issue(1'b0, 1'b0, 28'h0010000, {w[31:16], 8'hab, w[7:0]});
        issue(1'b0, 1'b1, 28'h0010001, {2{8'hab, w[7:0]}});
        drain();
        final_report();
    end
endmodule : dwtc_top_bench
